// File: src/velocity_pkg.sv
package velocity_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int CHANNELS = 4;
   localparam int COUNT_W  = 20;
   localparam int RESULT_W = 21;
   // doppler inputs, window, three strobes
   localparam int SYNC_W   = 8;

   // ----------------------------------------------------------------
   // preset values
   // ----------------------------------------------------------------
   localparam logic [COUNT_W-1:0] ALL_ONES      = 20'hFFFFF;
   // level left by the blocked clear ripple
   localparam logic [COUNT_W-1:0] PRESET_VALUE  = 20'hE18F5;
   // without inhibit the clear runs from stage 2 to the top
   localparam logic [COUNT_W-1:0] UNBLOCKED_KEEP = 20'h00001;
   localparam logic [COUNT_W-1:0] COUNT_ONE     = 20'h00001;
   localparam logic [COUNT_W-1:0] COUNT_RESET   = 20'h00000;
   // 923,894 once the window has opened
   localparam logic [COUNT_W-1:0] PRESET_COUNT  = 20'hE18F6;

   // ----------------------------------------------------------------
   // sync vector layout
   // ----------------------------------------------------------------
   localparam int SYNC_DOP_LSB = 0;
   localparam int SYNC_WIN     = 4;
   localparam int SYNC_INH     = 5;
   localparam int SYNC_ONES    = 6;
   localparam int SYNC_ZEROS   = 7;

   localparam logic [RESULT_W-1:0] RESULT_RESET = 21'h1FFFFF;
   localparam logic [CHANNELS-1:0] CHAN_RESET   = 4'h0;
   localparam logic [SYNC_W-1:0]   SYNC_RESET   = 8'h00;

endpackage

// File: src/input_sync.sv
`timescale 1ns/1ps
module input_sync
   import velocity_pkg::*;
(
   input  wire logic                            clock,
   input  wire logic                            rst_n,
   input  wire logic [velocity_pkg::SYNC_W-1:0] async,
   output logic      [velocity_pkg::SYNC_W-1:0] synced
);
   import velocity_pkg::*;

   logic [SYNC_W-1:0] stage1_reg;

   // first stage feeds only the second
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stage1_reg <= SYNC_RESET;
         synced     <= SYNC_RESET;
      end
      else
      begin
         stage1_reg <= async;
         synced     <= stage1_reg;
      end
   end

endmodule

// File: src/velocity_extract.sv
`timescale 1ns/1ps
module velocity_extract
   import velocity_pkg::*;
(
   input  wire logic                             clock,
   input  wire logic                             rst_n,
   input  wire logic [velocity_pkg::CHANNELS-1:0] shapedDopplerInput,
   input  wire logic                             velocityWindow,
   input  wire logic                             feedbackInhibitStrobe,
   input  wire logic                             presetOnesStrobe,
   input  wire logic                             presetZerosStrobe,
   output logic      [velocity_pkg::RESULT_W-1:0] resultChanA,
   output logic      [velocity_pkg::RESULT_W-1:0] resultChanB,
   output logic      [velocity_pkg::RESULT_W-1:0] resultChanC,
   output logic      [velocity_pkg::RESULT_W-1:0] resultChanD,
   output logic      [velocity_pkg::CHANNELS-1:0] startPhase
);
   import velocity_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // doubling by relabel plus inverted end phase, then complemented
   function automatic logic [RESULT_W-1:0] assembleResult(
      input logic [COUNT_W-1:0] count,
      input logic               phaseLevel
   );
      assembleResult = ~{count, ~phaseLevel};
   endfunction

   // carry out of the top stage is simply lost
   function automatic logic [COUNT_W-1:0] bumpCount(input logic [COUNT_W-1:0] count);
      bumpCount = count + COUNT_ONE;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0]   rawIn;
   logic [SYNC_W-1:0]   syncIn;
   logic [CHANNELS-1:0] dopSync;
   logic [CHANNELS-1:0] dopPrev_reg;
   logic [CHANNELS-1:0] dopRise;
   logic                winSync;
   logic                winPrev_reg;
   logic                winRise;
   logic                winFall;
   logic                inhSync;
   logic                onesSync;
   logic                zerosSync;
   logic                presetActive;

   assign rawIn = {presetZerosStrobe, presetOnesStrobe, feedbackInhibitStrobe,
                   velocityWindow, shapedDopplerInput};

   // strobes take the pins' delay, so their order holds
   input_sync syncInputs (
      .clock  (clock),
      .rst_n  (rst_n),
      .async  (rawIn),
      .synced (syncIn)
   );

   assign dopSync      = syncIn[SYNC_DOP_LSB +: CHANNELS];
   assign winSync      = syncIn[SYNC_WIN];
   assign inhSync      = syncIn[SYNC_INH];
   assign onesSync     = syncIn[SYNC_ONES];
   assign zerosSync    = syncIn[SYNC_ZEROS];
   assign presetActive = onesSync | zerosSync;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         dopPrev_reg <= CHAN_RESET;
         winPrev_reg <= 1'b0;
      end
      else
      begin
         dopPrev_reg <= dopSync;
         winPrev_reg <= winSync;
      end
   end

   // limitation: levels shorter than one clock can be missed
   // gated count clock
   assign dopRise = dopSync & ~dopPrev_reg & {CHANNELS{winSync}};
   assign winRise = winSync & ~winPrev_reg;
   assign winFall = ~winSync & winPrev_reg;

   // ----------------------------------------------------------------
   // velocity counters, four channels
   // ----------------------------------------------------------------
   logic [COUNT_W-1:0]  counter_reg [CHANNELS];
   logic [RESULT_W-1:0] result_reg  [CHANNELS];

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            counter_reg[c] <= COUNT_RESET;
         end
      end
      else
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            if (onesSync)
            begin
               counter_reg[c] <= ALL_ONES;
            end
            else if (zerosSync)
            begin
               // inhibit stops the ripple at stages 3, 5, 12, 18
               if (inhSync)
               begin
                  counter_reg[c] <= counter_reg[c] & PRESET_VALUE;
               end
               else
               begin
                  counter_reg[c] <= counter_reg[c] & UNBLOCKED_KEEP;
               end
            end
            else if (winRise)
            begin
               counter_reg[c] <= bumpCount(counter_reg[c]);
            end
            else if (dopRise[c])
            begin
               counter_reg[c] <= bumpCount(counter_reg[c]);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // phase capture
   // ----------------------------------------------------------------
   // start phase
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         startPhase <= CHAN_RESET;
      end
      else if (winRise)
      begin
         startPhase <= dopSync;
      end
   end

   // ----------------------------------------------------------------
   // result registers
   // ----------------------------------------------------------------
   // loaded once per window so readout sees a stable word
   // result held between windows
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            result_reg[c] <= RESULT_RESET;
         end
      end
      else
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            // relabel, complement, sign lands in bit 21
            // end level itself in bit 1
            if (winFall)
            begin
               result_reg[c] <= assembleResult(counter_reg[c], dopSync[c]);
            end
         end
      end
   end

   assign resultChanA = result_reg[0];
   assign resultChanB = result_reg[1];
   assign resultChanC = result_reg[2];
   assign resultChanD = result_reg[3];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   for (genvar g = 0; g < CHANNELS; g++)
   begin : chk
      a_ones_preset: assert property (
         @(posedge clock) disable iff (!rst_n)
         onesSync |=> counter_reg[g] == ALL_ONES)
         else $error("preset-ones did not set all stages");

      a_zeros_blocked: assert property (
         @(posedge clock) disable iff (!rst_n)
         zerosSync && inhSync && !onesSync
         |=> counter_reg[g] == ($past(counter_reg[g]) & PRESET_VALUE))
         else $error("blocked clear ripple wrong");

      a_zeros_sequence: assert property (
         @(posedge clock) disable iff (!rst_n)
         onesSync ##1 (zerosSync && inhSync && !onesSync)
         |=> counter_reg[g] == PRESET_VALUE)
         else $error("preset sequence left wrong value");

      a_zeros_free: assert property (
         @(posedge clock) disable iff (!rst_n)
         zerosSync && !inhSync && !onesSync
         |=> counter_reg[g] == ($past(counter_reg[g]) & UNBLOCKED_KEEP))
         else $error("unblocked clear ripple wrong");

      a_window_bump: assert property (
         @(posedge clock) disable iff (!rst_n)
         winRise && !presetActive
         |=> counter_reg[g] == bumpCount($past(counter_reg[g])))
         else $error("window start did not add one");

      a_edge_count: assert property (
         @(posedge clock) disable iff (!rst_n)
         !presetActive && !winRise && winSync && dopSync[g] && !dopPrev_reg[g]
         |=> counter_reg[g] == bumpCount($past(counter_reg[g])))
         else $error("gated edge not counted");

      a_wrap_zero: assert property (
         @(posedge clock) disable iff (!rst_n)
         !presetActive && (winRise || dopRise[g]) && counter_reg[g] == ALL_ONES
         |=> counter_reg[g] == COUNT_RESET)
         else $error("counter did not wrap to zero");

      a_closed_hold: assert property (
         @(posedge clock) disable iff (!rst_n)
         !presetActive && !winSync |=> $stable(counter_reg[g]))
         else $error("counter moved while window closed");

      a_idle_hold: assert property (
         @(posedge clock) disable iff (!rst_n)
         !presetActive && !winRise && !dopRise[g] |=> $stable(counter_reg[g]))
         else $error("counter moved without an edge");

      a_start_phase: assert property (
         @(posedge clock) disable iff (!rst_n)
         winRise |=> startPhase[g] == $past(dopSync[g]))
         else $error("start phase not captured");

      a_result_word: assert property (
         @(posedge clock) disable iff (!rst_n)
         winFall |=> result_reg[g] == ~{$past(counter_reg[g]), ~$past(dopSync[g])})
         else $error("result word not complemented relabel");

      a_result_lsb: assert property (
         @(posedge clock) disable iff (!rst_n)
         winFall |=> result_reg[g][0] == $past(dopSync[g]))
         else $error("bit 1 does not follow end phase");

      a_result_hold: assert property (
         @(posedge clock) disable iff (!rst_n)
         !winFall |=> $stable(result_reg[g]))
         else $error("result changed outside window end");

      a_reset_clear: assert property (
         @(posedge clock)
         !rst_n |=> counter_reg[g] == COUNT_RESET && result_reg[g] == RESULT_RESET)
         else $error("reset did not clear channel");

      a_preset_start: assert property (
         @(posedge clock) disable iff (!rst_n)
         winRise && !presetActive && counter_reg[g] == PRESET_VALUE
         |=> counter_reg[g] == PRESET_COUNT)
         else $error("window did not start from preset count");

      a_zeros_lower: assert property (
         @(posedge clock) disable iff (!rst_n)
         zerosSync && !onesSync
         |=> (counter_reg[g] & ~$past(counter_reg[g])) == COUNT_RESET)
         else $error("clear ripple raised a stage");

      a_outside_edge: assert property (
         @(posedge clock) disable iff (!rst_n)
         !presetActive && !winSync && dopSync[g] && !dopPrev_reg[g]
         |=> $stable(counter_reg[g]))
         else $error("edge outside window was counted");

      a_result_sign: assert property (
         @(posedge clock) disable iff (!rst_n)
         winFall |=> result_reg[g][RESULT_W-1] == ~$past(counter_reg[g][COUNT_W-1]))
         else $error("sign bit not in top result bit");

      a_result_double: assert property (
         @(posedge clock) disable iff (!rst_n)
         winFall |=> result_reg[g][RESULT_W-1:1] == ~$past(counter_reg[g]))
         else $error("count not relabelled into bits 2 to 21");

      a_phase_hold: assert property (
         @(posedge clock) disable iff (!rst_n)
         !winRise |=> $stable(startPhase[g]))
         else $error("start phase moved outside window start");
   end

endmodule

// File: verif/timing_unit_model.sv
`timescale 1ns/1ps
module timing_unit_model
   import velocity_pkg::*;
(
   input  wire logic                clock,
   output logic      [CHANNELS-1:0] dopplerOut,
   output logic                     windowOut,
   output logic                     inhibitOut,
   output logic                     onesOut,
   output logic                     zerosOut
);
   // ----------------------------------------------------------------
   // strobe and window timing
   // ----------------------------------------------------------------
   initial
   begin
      dopplerOut = '0;
      windowOut  = 1'b0;
      inhibitOut = 1'b0;
      onesOut    = 1'b0;
      zerosOut   = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // mode 0 full preset, 1 ones only, 2 clear without inhibit
   task automatic preset(input int mode);
      onesOut = 1'b1;
      step(2);
      onesOut = 1'b0;
      if (mode != 1)
      begin
         inhibitOut = (mode == 0);
         zerosOut   = 1'b1;
         step(2);
         zerosOut   = 1'b0;
         inhibitOut = 1'b0;
      end
      step(4);
   endtask

   // scaled Doppler clock: toggles spaced two cycles apart
   task automatic run_window(input logic [CHANNELS-1:0]      startLvl,
                             input logic [CHANNELS-1:0][7:0] tog);
      int maxT;
      maxT = 0;
      for (int k = 0; k < CHANNELS; k++)
         if (int'(tog[k]) > maxT)
            maxT = int'(tog[k]);
      dopplerOut = startLvl;
      step(4);
      windowOut = 1'b1;
      step(4);
      for (int i = 0; i < maxT; i++)
      begin
         for (int k = 0; k < CHANNELS; k++)
            if (i < int'(tog[k]))
               dopplerOut[k] = ~dopplerOut[k];
         step(2);
      end
      step(2);
      windowOut = 1'b0;
      step(1);
   endtask

   // edges outside the window must be ignored
   task automatic idle_toggle(input int n);
      for (int i = 0; i < n; i++)
      begin
         dopplerOut = ~dopplerOut;
         step(2);
      end
   endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import velocity_pkg::*;

   logic                          clock;
   logic                          rst_n;
   logic      [CHANNELS-1:0]      doppler;
   logic                          window;
   logic                          inhibit;
   logic                          ones;
   logic                          zeros;
   logic      [RESULT_W-1:0]      res [CHANNELS];
   logic      [CHANNELS-1:0]      startPhase;
   logic      [CHANNELS-1:0]      lvl;
   logic      [CHANNELS-1:0][7:0] tog;
   int                            errorCnt;
   int                            nChecks;
   integer                        seed;

   initial clock = 1'b0;
   always #5 clock = ~clock;

   velocity_extract u_velocity_extract (
      .clock                 (clock),
      .rst_n                 (rst_n),
      .shapedDopplerInput    (doppler),
      .velocityWindow        (window),
      .feedbackInhibitStrobe (inhibit),
      .presetOnesStrobe      (ones),
      .presetZerosStrobe     (zeros),
      .resultChanA           (res[0]),
      .resultChanB           (res[1]),
      .resultChanC           (res[2]),
      .resultChanD           (res[3]),
      .startPhase            (startPhase)
   );

   timing_unit_model u_timing_unit_model (
      .clock      (clock),
      .dopplerOut (doppler),
      .windowOut  (window),
      .inhibitOut (inhibit),
      .onesOut    (ones),
      .zerosOut   (zeros)
   );

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (errorCnt == 0 && nChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // count wraps at 20 bits; window start adds one
   function automatic logic [RESULT_W-1:0] expected(input logic [COUNT_W-1:0] base,
                                                     input logic [7:0]         t,
                                                     input logic               s);
      logic [COUNT_W-1:0] cnt;
      logic               endLvl;
      cnt    = base + COUNT_ONE + COUNT_W'(s ? t >> 1 : (t + 8'h01) >> 1);
      endLvl = s ^ t[0];
      return ~{cnt, ~endLvl};
   endfunction

   task automatic window_case(input int mode);
      logic [COUNT_W-1:0] base;
      base = (mode == 0) ? PRESET_VALUE : (mode == 1) ? ALL_ONES : UNBLOCKED_KEEP;
      u_timing_unit_model.preset(mode);
      u_timing_unit_model.run_window(lvl, tog);
      repeat (3) @(posedge clock);
      #1;
      for (int k = 0; k < CHANNELS; k++)
      begin
         check(res[k], expected(base, tog[k], lvl[k]));
         check(startPhase[k], lvl[k]);
      end
      u_timing_unit_model.idle_toggle(5);
      for (int k = 0; k < CHANNELS; k++)
      begin
         check(res[k], expected(base, tog[k], lvl[k]));
         check(startPhase[k], lvl[k]);
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      errorCnt = 0;
      nChecks  = 0;
      seed     = 32'h451F50FF;
      rst_n    = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      for (int k = 0; k < CHANNELS; k++)
         check(res[k], RESULT_RESET);
      rst_n = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      // empty windows, then a boundary count per channel
      lvl = 4'h0;
      tog = '0;
      window_case(0);
      lvl = 4'hF;
      tog = {8'h28, 8'h01, 8'h02, 8'h00};
      window_case(0);
      lvl = 4'h5;
      tog = {8'h03, 8'h00, 8'h07, 8'h10};
      window_case(1);
      lvl = 4'hA;
      window_case(2);
      for (int i = 0; i < 9; i++)
      begin
         lvl = CHANNELS'($random(seed));
         for (int k = 0; k < CHANNELS; k++)
            tog[k] = 8'($unsigned($random(seed)) % 32'h29);
         window_case(i % 3);
      end
      rst_n = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      for (int k = 0; k < CHANNELS; k++)
         check(res[k], RESULT_RESET);
      close_out();
   end

   initial
   begin
      repeat (100000) @(posedge clock);
      errorCnt++;
      close_out();
   end
endmodule
